// ### lssl_pkg.sv
// Shared constants and types for the LED sink shift/latch front end
package lssl_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int          CH_NUM         = 16;         // Sink channels
  localparam int          FIFO_DEPTH     = 16;         // Frames buffered
  localparam int          SYNC_STAGES    = 2;          // Pin synchroniser depth
  localparam int          CHAIN_TAP      = 8;          // Stage seen by chain output
  localparam int          REF_PERIOD_NS  = 20;         // Block clock period
  localparam int          LINK_PERIOD_NS = 160;        // Serial clock period
  localparam int          LINK_SAMPLES   = LINK_PERIOD_NS / REF_PERIOD_NS;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_RST       = 16'h0000;
  localparam logic [15:0] DIAG_RST       = 16'h0000;
  localparam logic        CHAIN_RST      = 1'h1;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LSSL_NORMAL,
    LSSL_GLOBAL,
    LSSL_TEMP,
    LSSL_OPEN,
    LSSL_SHORT
  } lssl_mode_t;

endpackage

// ### lssl_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module lssl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // Metastability chain; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else if (ce_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

// ### lssl_fifo.sv
// Frame FIFO between the shift register and the data register
`timescale 1ns/100ps
module lssl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  // Pointer advance that also works for depths not a power of two
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign in_ready_out  = (count_q != CW'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = mem[rd_ptr_q];
  assign push          = ce_in && in_valid_in && in_ready_out;
  assign pop           = ce_in && out_valid_out && out_ready_in;

  // Storage needs no reset; only words below count are ever read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + CW'(1);
      end else if (pop && !push) begin
        count_q <= count_q - CW'(1);
      end
    end
  end

endmodule

// ### lssl_top.sv
// Serial shift/latch front end of a 16-channel LED sink driver
//
// Overview of operation
// - Each serial clock rising edge with load low samples serial_in and advances the shift register.
// - Sixteen sink outputs, each driven by one bit of the stored pattern.
// - Displayed pattern sits in a data register apart from the shift register.
// - Normal mode: a bit reaches serial_chain_out 8.5 clocks after sampling.
// - In error modes each qualifying serial clock edge steps to the next mode.
// - Global error mode: chain output low on error, high when clean.
// - drive_enable_low low enables all sinks, high disables them, any mode.
// - Global fault status is captured during load and held internally.
// - Per-channel temperature, open and short results kept for serial read-back.
// - Error modes run the sinks at reduced diagnostic current.
`timescale 1ns/100ps
module lssl_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        CE_IN,
  input  wire logic        SERIAL_CLK_IN,
  input  wire logic        SERIAL_IN,
  input  wire logic        LOAD_STROBE_IN,
  input  wire logic        DRIVE_ENABLE_LOW_IN,
  input  wire logic [15:0] OVERTEMP_SENSE_IN,
  input  wire logic [15:0] OPEN_SENSE_IN,
  input  wire logic [15:0] SHORT_SENSE_IN,
  output logic             SERIAL_CHAIN_OUT,
  output logic      [15:0] SINK_OUTPUTS_OUT,
  output logic             LOW_CURRENT_OUT,
  output logic             ERROR_MODE_OUT,
  output logic             LOAD_READY_OUT
);

  localparam int N = lssl_pkg::CH_NUM;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 rst_meta_q;
  logic                 rst_n_q;
  logic [3:0]           pins_s;
  logic [3*N-1:0]       sense_s;
  logic                 sclk_s;
  logic                 ser_in_s;
  logic                 load_s;
  logic                 en_low_s;
  logic [N-1:0]         temp_s;
  logic [N-1:0]         open_s;
  logic [N-1:0]         short_s;
  logic                 sclk_prev_q;
  logic                 load_prev_q;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 load_rise;
  lssl_pkg::lssl_mode_t mode_q;
  logic                 normal;
  logic [N-1:0]         shift_q;
  logic [N-1:0]         data_q;
  logic [N-1:0]         temp_q;
  logic [N-1:0]         open_q;
  logic [N-1:0]         short_q;
  logic                 global_err_q;
  logic                 frame_push;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [N-1:0]         fifo_out_data;
  logic                 frame_pop;

  // Mode sequence stepped by serial clock edges in error mode
  function automatic lssl_pkg::lssl_mode_t next_mode(input lssl_pkg::lssl_mode_t m);
    unique case (m)
      lssl_pkg::LSSL_NORMAL: next_mode = lssl_pkg::LSSL_GLOBAL;
      lssl_pkg::LSSL_GLOBAL: next_mode = lssl_pkg::LSSL_TEMP;
      lssl_pkg::LSSL_TEMP:   next_mode = lssl_pkg::LSSL_OPEN;
      lssl_pkg::LSSL_OPEN:   next_mode = lssl_pkg::LSSL_SHORT;
      lssl_pkg::LSSL_SHORT:  next_mode = lssl_pkg::LSSL_NORMAL;
      default:               next_mode = lssl_pkg::LSSL_NORMAL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Assert at once, release through two flops to avoid recovery races
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_meta_q <= 1'h0;
      rst_n_q    <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Serial clock is only sampled; its edges are found below
  lssl_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (rst_n_q),
    .ce_in    (CE_IN),
    .d_in     ({SERIAL_CLK_IN, SERIAL_IN, LOAD_STROBE_IN, DRIVE_ENABLE_LOW_IN}),
    .q_out    (pins_s)
  );

  // Fault sense levels come from the analogue side
  lssl_sync #(
    .WIDTH (3 * N)
  ) u_sense_sync (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (rst_n_q),
    .ce_in    (CE_IN),
    .d_in     ({OVERTEMP_SENSE_IN, OPEN_SENSE_IN, SHORT_SENSE_IN}),
    .q_out    (sense_s)
  );

  assign {sclk_s, ser_in_s, load_s, en_low_s} = pins_s;
  assign {temp_s, open_s, short_s}            = sense_s;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_prev_q <= 1'h0;
      load_prev_q <= 1'h0;
    end else if (CE_IN) begin
      sclk_prev_q <= sclk_s;
      load_prev_q <= load_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign load_rise = load_s && !load_prev_q;
  assign normal    = (mode_q == lssl_pkg::LSSL_NORMAL);

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  // A serial clock edge with load held high enters or steps error modes
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q <= lssl_pkg::LSSL_NORMAL;
    end else if (CE_IN && sclk_rise && load_s) begin
      mode_q <= next_mode(mode_q);
    end
  end

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  // Stepping into a report mode parks that report for read-back
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_q <= lssl_pkg::DATA_RST;
    end else if (CE_IN && sclk_rise) begin
      if (!normal && load_s) begin
        unique case (next_mode(mode_q))
          lssl_pkg::LSSL_TEMP:  shift_q <= temp_q;
          lssl_pkg::LSSL_OPEN:  shift_q <= open_q;
          lssl_pkg::LSSL_SHORT: shift_q <= short_q;
          default:              shift_q <= shift_q;
        endcase
      end else if (!load_s) begin
        shift_q <= {shift_q[N-2:0], ser_in_s};
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault capture
  // ----------------------------------------------------------------
  // Sampled at load so the report matches the pattern just loaded
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      temp_q       <= lssl_pkg::DIAG_RST;
      open_q       <= lssl_pkg::DIAG_RST;
      short_q      <= lssl_pkg::DIAG_RST;
      global_err_q <= 1'h0;
    end else if (CE_IN && load_rise && normal) begin
      temp_q       <= temp_s;
      open_q       <= open_s;
      short_q      <= short_s;
      global_err_q <= |{temp_s, open_s, short_s};
    end
  end

  // ----------------------------------------------------------------
  // Frame buffer and data register
  // ----------------------------------------------------------------
  // A load while the buffer is full is dropped; LOAD_READY_OUT warns
  assign frame_push = load_rise && normal;
  assign frame_pop  = CE_IN && fifo_out_valid && normal;

  lssl_fifo #(
    .WIDTH (N),
    .DEPTH (lssl_pkg::FIFO_DEPTH)
  ) u_frame_fifo (
    .clk_in        (REF_CLK_IN),
    .rst_n_in      (rst_n_q),
    .ce_in         (CE_IN),
    .in_valid_in   (frame_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (shift_q),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (normal),
    .out_data_out  (fifo_out_data)
  );

  // Pattern frozen during diagnostics; no frames are pushed meanwhile
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_q <= lssl_pkg::DATA_RST;
    end else if (frame_pop) begin
      data_q <= fifo_out_data;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  // One sink per pattern bit, gated by the enable in every mode
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      SINK_OUTPUTS_OUT <= '0;
      LOW_CURRENT_OUT  <= 1'h0;
      ERROR_MODE_OUT   <= 1'h0;
      LOAD_READY_OUT   <= 1'h0;
    end else if (CE_IN) begin
      SINK_OUTPUTS_OUT <= data_q & {N{!en_low_s}};
      LOW_CURRENT_OUT  <= !normal;
      ERROR_MODE_OUT   <= !normal;
      LOAD_READY_OUT   <= fifo_in_ready;
    end
  end

  // Falling edge retime adds the half cycle for cascaded parts
  always_ff @(posedge REF_CLK_IN or negedge rst_n_q) begin
    if (!rst_n_q) begin
      SERIAL_CHAIN_OUT <= lssl_pkg::CHAIN_RST;
    end else if (CE_IN) begin
      if (mode_q == lssl_pkg::LSSL_GLOBAL) begin
        SERIAL_CHAIN_OUT <= !global_err_q;
      end else if (sclk_fall) begin
        SERIAL_CHAIN_OUT <= shift_q[lssl_pkg::CHAIN_TAP];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SHIFT: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && sclk_rise && !load_s |=> shift_q == {$past(shift_q[N-2:0]), $past(ser_in_s)})
    else $error("shift register did not advance on serial clock");

  AST_CHAIN: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && sclk_fall && mode_q != lssl_pkg::LSSL_GLOBAL
      |=> SERIAL_CHAIN_OUT == $past(shift_q[lssl_pkg::CHAIN_TAP]))
    else $error("chain output not taken from tap on falling edge");

  AST_GLOBAL: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && mode_q == lssl_pkg::LSSL_GLOBAL ##1 CE_IN
      |=> SERIAL_CHAIN_OUT == !$past(global_err_q, 2))
    else $error("global error not shown on chain output");

  AST_ENABLE: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN |=> SINK_OUTPUTS_OUT == ($past(data_q) & {N{!$past(en_low_s)}}))
    else $error("sink outputs disagree with pattern and enable");

  AST_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    !normal |=> $stable(data_q))
    else $error("displayed pattern changed during diagnostics");

  AST_STEP: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && sclk_rise && load_s && !normal |=> mode_q == next_mode($past(mode_q)))
    else $error("error mode did not step");

  AST_CAPTURE: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && load_rise && normal |=> global_err_q == $past(|{temp_s, open_s, short_s}))
    else $error("global fault not captured at load");

  AST_REPORT: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && sclk_rise && load_s && mode_q == lssl_pkg::LSSL_GLOBAL
      |=> shift_q == $past(temp_q))
    else $error("temperature report not parked for read-back");

  AST_LOWCUR: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && !normal |=> LOW_CURRENT_OUT)
    else $error("diagnostics not at reduced current");

  AST_LOAD: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    CE_IN && frame_push && !fifo_out_valid ##1 CE_IN && normal |=> data_q == $past(shift_q, 2))
    else $error("loaded frame did not reach data register");

  COV_ERROR_ENTRY: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    normal ##1 mode_q == lssl_pkg::LSSL_GLOBAL);

  COV_GLOBAL_FAULT: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    mode_q == lssl_pkg::LSSL_GLOBAL && global_err_q ##1 !SERIAL_CHAIN_OUT);

  COV_FRAME: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    frame_push ##[1:4] frame_pop);

  COV_FULL: cover property (@(posedge REF_CLK_IN) disable iff (!rst_n_q)
    !fifo_in_ready);

endmodule

// ### lssl_host_model.sv
// Host controller model driving the serial link of the sink driver
`timescale 1ns/100ps
module lssl_host_model (
  input  wire logic clk_in,
  output logic      serial_clk_out,
  output logic      serial_data_out,
  output logic      load_strobe_out,
  output logic      probe_out
);
  localparam int HALF = lssl_pkg::LINK_SAMPLES / 2;  // Half a serial period, in block clocks

  logic pend;
  logic last;

  // Idle link: clock low and still, strobe low
  initial begin
    serial_clk_out  = 1'h0;
    serial_data_out = 1'h1;
    load_strobe_out = 1'h0;
    probe_out       = 1'h0;
    pend            = 1'h0;
    last            = 1'h0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // One bit; data leads the rise by half a period for synchroniser setup
  task automatic send_bit(input logic b, input logic chk);
    serial_data_out = b;
    last = b;
    wait_cyc(HALF);
    serial_clk_out = 1'h1;
    probe_out = pend;  // Previous fall has settled by now
    wait_cyc(1);
    probe_out = 1'h0;
    wait_cyc(HALF - 1);
    serial_clk_out = 1'h0;
    pend = chk;
  endtask

  // Burst end: data released shows the inverse, clock stands still
  task automatic flush();
    serial_data_out = ~last;
    wait_cyc(HALF);
    probe_out = pend;
    wait_cyc(1);
    probe_out = 1'h0;
    pend = 1'h0;
  endtask

  // Strobe only after whole frames, 16 bits a device, clock held low
  task automatic load();
    load_strobe_out = 1'h1;
    wait_cyc(HALF);
    load_strobe_out = 1'h0;
    wait_cyc(3 * HALF);
  endtask

  // Mode step: serial clock pulse while the strobe is high
  task automatic step();
    load_strobe_out = 1'h1;
    wait_cyc(HALF);
    serial_clk_out = 1'h1;
    wait_cyc(HALF);
    serial_clk_out = 1'h0;
    wait_cyc(HALF);
    load_strobe_out = 1'h0;
    wait_cyc(2 * HALF);
  endtask

  // Ask the bench to sample the chain output once
  task automatic probe();
    wait_cyc(1);
    probe_out = 1'h1;
    wait_cyc(1);
    probe_out = 1'h0;
  endtask
endmodule

// ### lssl_top_tb.sv
// Self-checking bench for the LED sink shift/latch front end
`timescale 1ns/100ps
module lssl_top_tb;
  logic        ref_clk;
  logic        rst_b;
  logic        ce;
  logic        drive_en_low;
  logic [15:0] ot_sense;
  logic [15:0] op_sense;
  logic [15:0] sh_sense;
  logic        ser_clk;
  logic        ser_data;
  logic        load_strobe;
  logic        probe;
  logic        chain_out;
  logic [15:0] sink_out;
  logic        low_cur;
  logic        err_mode;
  logic        load_ready;
  int          errors;
  int          n_compared;
  int          seed;
  logic [1:0]  chain_q[$];  // {care, value}
  logic [15:0] sink_q[$];
  logic [1:0]  mode_q[$];
  logic [15:0] sr;           // Shift register model
  int          sr_known;     // Low bits of sr that are known
  logic [15:0] disp;         // Data register model
  logic [15:0] shown;
  logic [1:0]  mode_seen;
  logic        mon_on;
  logic [1:0]  cn;

  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  lssl_top lssl_top_i (
    .REF_CLK_IN          (ref_clk),
    .RST_B_IN            (rst_b),
    .CE_IN               (ce),
    .SERIAL_CLK_IN       (ser_clk),
    .SERIAL_IN           (ser_data),
    .LOAD_STROBE_IN      (load_strobe),
    .DRIVE_ENABLE_LOW_IN (drive_en_low),
    .OVERTEMP_SENSE_IN   (ot_sense),
    .OPEN_SENSE_IN       (op_sense),
    .SHORT_SENSE_IN      (sh_sense),
    .SERIAL_CHAIN_OUT    (chain_out),
    .SINK_OUTPUTS_OUT    (sink_out),
    .LOW_CURRENT_OUT     (low_cur),
    .ERROR_MODE_OUT      (err_mode),
    .LOAD_READY_OUT      (load_ready)
  );

  lssl_host_model lssl_host_model_i (
    .clk_in          (ref_clk),
    .serial_clk_out  (ser_clk),
    .serial_data_out (ser_data),
    .load_strobe_out (load_strobe),
    .probe_out       (probe)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  // Empty queue makes the inverse the note: chain and sink checks fail, a mode change to ~mode_seen passes
  always @(posedge ref_clk) begin
    if (mon_on) begin
      if (probe) begin
        cn = chain_q.size() ? chain_q.pop_front() : {1'b1, ~chain_out};
        if (cn[1]) check({15'h0, chain_out}, {15'h0, cn[0]}, "chain");
      end
      if (sink_out !== shown) begin
        check(sink_out, sink_q.size() ? sink_q.pop_front() : ~sink_out, "sinks");
        shown = sink_out;
      end
      if ({err_mode, low_cur} !== mode_seen) begin
        cn = mode_q.size() ? mode_q.pop_front() : ~mode_seen;
        check({14'h0, err_mode, low_cur}, {14'h0, cn}, "mode");
        mode_seen = {err_mode, low_cur};
      end
    end
  end

  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  // Shift 16 bits, first bit ends in channel 15; note chain value per fall
  task automatic shift(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      sr = {sr[14:0], v[i]};
      sr_known++;
      chain_q.push_back({sr_known > 8, sr[8]});
      lssl_host_model_i.send_bit(v[i], 1'h1);
    end
    lssl_host_model_i.flush();
  endtask

  // Load strobe: shown pattern changes only if new and sinks enabled
  task automatic commit();
    if (sr !== disp && !drive_en_low) sink_q.push_back(sr);
    disp = sr;
    lssl_host_model_i.load();
    repeat (4) @(negedge ref_clk);
  endtask

  // Full error-mode cycle; the strobe of each step from normal is a load too
  task automatic mode_pass(input logic [15:0] ot, input logic [15:0] op, input logic [15:0] sh);
    logic [15:0] rep[3];
    rep = '{ot, op, sh};
    ot_sense = ot;
    op_sense = op;
    sh_sense = sh;
    shift(16'($random(seed)));
    commit();
    mode_q.push_back(2'b11);
    lssl_host_model_i.step();
    sr_known = 0;
    chain_q.push_back({1'b1, ~|(ot | op | sh)});
    lssl_host_model_i.probe();
    for (int m = 0; m < 3; m++) begin
      lssl_host_model_i.step();
      sr = rep[m];
      sr_known = 16;
      shift(16'($random(seed)));
    end
    mode_q.push_back(2'b00);
    lssl_host_model_i.step();
    sr_known = 0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    ce = 1'h1;
    drive_en_low = 1'h0;
    ot_sense = 16'h0000;
    op_sense = 16'h0000;
    sh_sense = 16'h0000;
    seed = 32'hcef29dc0;
    errors = 0;
    n_compared = 0;
    sr = 16'h0000;
    sr_known = 0;
    disp = 16'h0000;
    shown = 16'h0000;
    mode_seen = 2'b00;
    mon_on = 1'h0;
    repeat (12) @(negedge ref_clk);
    check(sink_out, 16'h0000, "sinks in reset");
    check({12'h0, chain_out, low_cur, err_mode, load_ready}, 16'h0008, "flags in reset");
    rst_b = 1'h1;
    repeat (6) @(negedge ref_clk);
    check({15'h0, load_ready}, 16'h0001, "frame room");
    mon_on = 1'h1;
    $display("test reset done");
    // Back-to-back random frames through shift and data registers
    for (int i = 0; i < 6; i++) begin
      shift(16'($random(seed)));
      commit();
    end
    $display("test frames done");
    // Sinks gated off, a frame loaded meanwhile, then gated on again
    drive_en_low = 1'h1;
    sink_q.push_back(16'h0000);
    repeat (8) @(negedge ref_clk);
    shift(16'($random(seed)));
    commit();
    drive_en_low = 1'h0;
    sink_q.push_back(disp);
    repeat (8) @(negedge ref_clk);
    $display("test enable done");
    // Strobe while frozen must be lost; a later strobe loads the frame
    shift(16'($random(seed)));
    ce = 1'h0;
    lssl_host_model_i.load();
    ce = 1'h1;
    repeat (8) @(negedge ref_clk);
    commit();
    $display("test freeze done");
    mode_pass(16'h0000, 16'h0000, 16'h0000);
    mode_pass(16'($random(seed)) | 16'h0001, 16'($random(seed)), 16'($random(seed)));
    shift(16'($random(seed)));
    commit();
    repeat (10) @(negedge ref_clk);
    check(16'(sink_q.size() + chain_q.size() + mode_q.size()), 16'h0000, "leftover notes");
    $display("test modes done");
    wrap_up();
  end

  // Whole run is under 10k block clocks; this cuts a hang at 20k
  initial begin
    #400000;
    errors++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'h0, 1'h1);
    wrap_up();
  end
endmodule
